// ==== pkg/path_status_pkg.sv ====
// Shared constants for the path status overhead block and its far end
package path_status_pkg;
  // Own register map, byte addresses on APB
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  TX_OCTETS_OFS  = 8'h04;
  localparam logic [7:0]  STATUS_OFS     = 8'h08;
  localparam logic [7:0]  PENDING_OFS    = 8'h0C;
  localparam logic [7:0]  MASK_A_OFS     = 8'h10;
  localparam logic [7:0]  MASK_B_OFS     = 8'h14;

  // Control fields
  localparam int          CTRL_RX_ENH_BIT = 0;
  localparam int          CTRL_TX_ENH_BIT = 1;
  localparam int          CTRL_TIM_BIT    = 2;
  localparam logic [2:0]  CTRL_RESET      = 3'h3;

  // Event bits, shared by status and pending registers; mask registers hold bits 0..2 only
  localparam int          EV_FAR_DEFECT   = 0;
  localparam int          EV_PAYLOAD      = 1;
  localparam int          EV_SERVER       = 2;
  localparam int          EV_CONNECT      = 3;
  localparam int          EV_W            = 4;

  // Transmit octet fields and reset value
  localparam int          USER_LSB        = 0;
  localparam int          MFI_LSB         = 8;
  localparam int          GROW1_LSB       = 16;
  localparam int          GROW2_LSB       = 24;
  localparam logic [31:0] TX_OCTETS_RESET = 32'h0000_0000;

  // Three bit defect codes carried in path status bits 5..7
  localparam logic [2:0]  CODE_NONE_A     = 3'h0;
  localparam logic [2:0]  CODE_NONE_B     = 3'h3;
  localparam logic [2:0]  CODE_RDI_A      = 3'h4;
  localparam logic [2:0]  CODE_RDI_B      = 3'h7;
  localparam logic [2:0]  CODE_ENH_NONE   = 3'h1;
  localparam logic [2:0]  CODE_PAYLOAD    = 3'h2;
  localparam logic [2:0]  CODE_SERVER     = 3'h5;
  localparam logic [2:0]  CODE_CONNECT    = 3'h6;

  // Error count limits and persistence
  localparam logic [3:0]  REI_MAX         = 4'h8;
  localparam logic [3:0]  PERSIST_FRAMES  = 4'hA;
  localparam logic [7:0]  OCTET_RESET     = 8'h00;
endpackage : path_status_pkg

// ==== pkg/path_oh_if.sv ====
// Per-frame path overhead octets exchanged by the two framers
`timescale 1ns/1ps
interface path_oh_if;
  logic       dev_frame;  // Device frame strobe, one cycle
  logic [7:0] dev_g1;     // Device path status octet
  logic [7:0] dev_user;   // Device user channel octet
  logic [7:0] dev_mfi;    // Device multiframe octet
  logic [7:0] dev_grow1;  // Device first growth octet
  logic [7:0] dev_grow2;  // Device second growth octet
  logic       far_frame;  // Far end frame strobe, one cycle
  logic [7:0] far_g1;     // Far end path status octet

  modport device (output dev_frame, dev_g1, dev_user, dev_mfi, dev_grow1, dev_grow2,
                  input  far_frame, far_g1);
  modport far_end (input  dev_frame, dev_g1, dev_user, dev_mfi, dev_grow1, dev_grow2,
                   output far_frame, far_g1);
endinterface : path_oh_if

// ==== design/far_path_framer.sv ====
// Far end path terminating framer: sends and decodes path status
`timescale 1ns/1ps
module far_path_framer
  import path_status_pkg::*;
(
  input  wire logic       clk,             // 10 MHz clock
  input  wire logic       rstn,            // Async reset, active low
  path_oh_if.far_end      oh,              // Overhead link
  input  wire logic       send_frame,      // Send one frame now
  input  wire logic       enhanced_sel,    // 1: three bit codes
  input  wire logic [3:0] rei_count,       // Error count to report
  input  wire logic       server_cause,    // Alarm or pointer loss
  input  wire logic       connect_cause,   // Unequipped or trace mismatch
  input  wire logic       payload_cause,   // Label mismatch or delineation
  output logic            rx_frame_q,      // Device frame seen, pulse
  output logic [3:0]      rx_rei_q,        // Error count from device
  output logic [2:0]      rx_code_q,       // Defect code from device
  output logic            rx_rdi_q,        // Single bit indication
  output logic [31:0]     rx_octets_q      // Growth, mfi, user octets
);
  logic [2:0] tx_code;
  logic [3:0] rei_clamped;

  // Count above the legal range is clamped, never wraps
  assign rei_clamped = (rei_count > REI_MAX) ? REI_MAX : rei_count;

  // Code choice mirrors the device priority
  always_comb begin
    if (!enhanced_sel) begin
      tx_code = server_cause ? CODE_RDI_A : CODE_NONE_A;
    end else if (server_cause) begin
      tx_code = CODE_SERVER;
    end else if (connect_cause) begin
      tx_code = CODE_CONNECT;
    end else if (payload_cause) begin
      tx_code = CODE_PAYLOAD;
    end else begin
      tx_code = CODE_ENH_NONE;
    end
  end

  // Transmit octet toward the device
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oh.far_frame <= 1'b0;
      oh.far_g1    <= OCTET_RESET;
    end else begin
      oh.far_frame <= send_frame;
      if (send_frame) begin
        oh.far_g1 <= {rei_clamped, tx_code, 1'b0};
      end
    end
  end

  // Receive decode; bit 8 is ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_frame_q  <= 1'b0;
      rx_rei_q    <= 4'h0;
      rx_code_q   <= 3'h0;
      rx_rdi_q    <= 1'b0;
      rx_octets_q <= 32'h0000_0000;
    end else begin
      rx_frame_q <= oh.dev_frame;
      if (oh.dev_frame) begin
        rx_rei_q    <= oh.dev_g1[7:4];
        rx_code_q   <= oh.dev_g1[3:1];
        rx_rdi_q    <= oh.dev_g1[3];
        rx_octets_q <= {oh.dev_grow2, oh.dev_grow1, oh.dev_mfi, oh.dev_user};
      end
    end
  end
endmodule : far_path_framer

// ==== design/path_status_oh.sv ====
// Device end: path status transmit, receive persistence, events, APB registers
// Behaviour
// - Separate rx/tx mode select, both default enhanced
// - Bits 1-4 carry error count 0-8
// - Single mode: bit5 indicator, bits6-7 zero, bit8 ignored
// - Enhanced mode: bits 5-7 carry defect code
// - Single: 000/011 clear, 100/111 defect
// - Enhanced 001 none, 010 payload defect
// - Enhanced 101 server defect on alarm/pointer loss
// - Enhanced 110 connectivity on unequipped or trace
// - Transmit priority server, connectivity, payload, none
// - Software forces trace mismatch for connectivity code
// - Single mode declares after ten contiguous frames
// - Single mode clears after ten absent frames
// - Defect event pending, live bit, two masks
// - Enhanced declares when code persists ten frames
// - Enhanced clears after ten frames without code
// - Payload code latches status, pending, masks
// - Server code latches status, pending, masks
// - Connectivity pending, live bit, shares defect masks
// - User channel octet programmable, default zero
// - Multiframe octet programmable, default zero
// - Two growth octets programmable, default zero
// - Error count from queue, zero when none
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module path_status_oh
  import path_status_pkg::*;
(
  input  wire logic        clk,          // 10 MHz clock
  input  wire logic        rstn,         // Async reset, active low
  path_oh_if.device        oh,           // Overhead link
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB write
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic [31:0]      prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  input  wire logic        tx_frame,     // Local transmit frame tick
  input  wire logic        rei_valid,    // Error count queue has a word
  input  wire logic [3:0]  rei_count,    // Error count from queue
  input  wire logic        ais_cause,    // Local alarm indication
  input  wire logic        lop_cause,    // Local loss of pointer
  input  wire logic        plm_cause,    // Local label mismatch
  input  wire logic        lcd_cause,    // Local delineation loss
  input  wire logic        uneq_cause,   // Local unequipped path
  output logic             irq_out_a,    // Interrupt A, level
  output logic             irq_out_b     // Interrupt B, level
);
  logic [2:0]      ctrl_q, decl_code_q, last_code_q, rx_code, tx_code;
  logic [31:0]     tx_octets_q, rd_mux;
  logic [EV_W-1:0] pend_q, mask_a_q, mask_b_q, ev_set, gate_a, gate_b;
  logic [3:0]      hit_cnt_q, miss_cnt_q, rei_hold_q;
  logic            far_payload_defect_latched, far_server_defect_latched;
  logic            declared_q, rei_have_q, force_tim, far_defect_live, far_connect_defect_live;
  logic            rx_enhanced_defect_sel, tx_enhanced_defect_sel;
  logic            access, done, wr_done, rd_done, addr_ok, hit, same, reach;

  assign rx_enhanced_defect_sel = ctrl_q[CTRL_RX_ENH_BIT];
  assign tx_enhanced_defect_sel = ctrl_q[CTRL_TX_ENH_BIT];
  assign force_tim              = ctrl_q[CTRL_TIM_BIT];

  // APB handshake: one wait cycle so read data comes from a flop
  assign access  = psel && penable && !pready;
  assign done    = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite && !pslverr;
  assign addr_ok = (paddr == CTRL_OFS) || (paddr == TX_OCTETS_OFS) ||
                   (paddr == STATUS_OFS) || (paddr == PENDING_OFS) ||
                   (paddr == MASK_A_OFS) || (paddr == MASK_B_OFS);

  // Live view of the declared state
  assign far_defect_live         = declared_q;
  assign far_connect_defect_live = declared_q && rx_enhanced_defect_sel &&
                                   (decl_code_q == CODE_CONNECT);

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      CTRL_OFS:      rd_mux[2:0] = ctrl_q;
      TX_OCTETS_OFS: rd_mux      = tx_octets_q;
      STATUS_OFS: begin
        rd_mux[EV_FAR_DEFECT] = far_defect_live;
        rd_mux[EV_PAYLOAD]    = far_payload_defect_latched;
        rd_mux[EV_SERVER]     = far_server_defect_latched;
        rd_mux[EV_CONNECT]    = far_connect_defect_live;
      end
      PENDING_OFS:   rd_mux[EV_W-1:0] = pend_q;
      MASK_A_OFS:    rd_mux[EV_W-1:0] = mask_a_q;
      MASK_B_OFS:    rd_mux[EV_W-1:0] = mask_b_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // APB answer flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && !addr_ok;
      if (access) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Software written registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q      <= CTRL_RESET;
      tx_octets_q <= TX_OCTETS_RESET;
      mask_a_q    <= '0;
      mask_b_q    <= '0;
    end else if (wr_done) begin
      case (paddr)
        CTRL_OFS:      ctrl_q      <= pwdata[2:0];
        TX_OCTETS_OFS: tx_octets_q <= pwdata;
        MASK_A_OFS:    mask_a_q    <= {1'b0, pwdata[2:0]};
        MASK_B_OFS:    mask_b_q    <= {1'b0, pwdata[2:0]};
        default:       ctrl_q      <= ctrl_q;
      endcase
    end
  end

  // Receive decode: code is bits 5..7, bit 8 not looked at
  assign rx_code = oh.far_g1[3:1];
  assign hit     = rx_enhanced_defect_sel ?
                   ((rx_code == CODE_PAYLOAD) || (rx_code == CODE_SERVER) ||
                    (rx_code == CODE_CONNECT)) :
                   oh.far_g1[3];
  assign same    = !rx_enhanced_defect_sel || (rx_code == last_code_q);
  assign reach   = oh.far_frame && hit && (same ? (hit_cnt_q == PERSIST_FRAMES - 4'h1)
                                                : (PERSIST_FRAMES == 4'h1));

  // Persistence: ten frames to declare, ten clean frames to clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      declared_q  <= 1'b0;
      decl_code_q <= CODE_ENH_NONE;
      last_code_q <= CODE_ENH_NONE;
      hit_cnt_q   <= 4'h0;
      miss_cnt_q  <= 4'h0;
    end else if (oh.far_frame) begin
      if (hit) begin
        miss_cnt_q  <= 4'h0;
        last_code_q <= rx_code;
        if (!same) begin
          hit_cnt_q <= 4'h1;
        end else if (hit_cnt_q != PERSIST_FRAMES) begin
          hit_cnt_q <= hit_cnt_q + 4'h1;
        end
        if (reach) begin
          declared_q  <= 1'b1;
          decl_code_q <= rx_code;
        end
      end else begin
        hit_cnt_q <= 4'h0;
        if (miss_cnt_q != PERSIST_FRAMES) begin
          miss_cnt_q <= miss_cnt_q + 4'h1;
        end
        if (miss_cnt_q == PERSIST_FRAMES - 4'h1) begin
          declared_q <= 1'b0;
        end
      end
    end
  end

  // Events: a declaration, tagged by code in enhanced mode
  always_comb begin
    ev_set                = '0;
    ev_set[EV_FAR_DEFECT] = reach && !declared_q;
    ev_set[EV_PAYLOAD]    = reach && rx_enhanced_defect_sel &&
                            (rx_code == CODE_PAYLOAD);
    ev_set[EV_SERVER]     = reach && rx_enhanced_defect_sel &&
                            (rx_code == CODE_SERVER);
    ev_set[EV_CONNECT]    = reach && rx_enhanced_defect_sel &&
                            (rx_code == CODE_CONNECT);
  end

  // Pending bits clear only what the read returned, so no event slips past
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~((rd_done && paddr == PENDING_OFS) ? prdata[EV_W-1:0] : '0))
                | ev_set;
    end
  end

  // Latched high status bits, cleared the same way by a status read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      far_payload_defect_latched <= 1'b0;
      far_server_defect_latched  <= 1'b0;
    end else begin
      far_payload_defect_latched <= (far_payload_defect_latched &&
        !(rd_done && paddr == STATUS_OFS && prdata[EV_PAYLOAD])) || ev_set[EV_PAYLOAD];
      far_server_defect_latched  <= (far_server_defect_latched &&
        !(rd_done && paddr == STATUS_OFS && prdata[EV_SERVER])) || ev_set[EV_SERVER];
    end
  end

  // Connectivity event reuses the far defect mask bit
  assign gate_a = {mask_a_q[EV_FAR_DEFECT], mask_a_q[EV_SERVER:0]};
  assign gate_b = {mask_b_q[EV_FAR_DEFECT], mask_b_q[EV_SERVER:0]};

  // Interrupt outputs, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_out_a <= 1'b0;
      irq_out_b <= 1'b0;
    end else begin
      irq_out_a <= |(pend_q & gate_a);
      irq_out_b <= |(pend_q & gate_b);
    end
  end

  // Error count hand-off: newest word wins, a frame without one sends zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rei_hold_q <= 4'h0;
      rei_have_q <= 1'b0;
    end else if (rei_valid) begin
      rei_hold_q <= (rei_count > REI_MAX) ? REI_MAX : rei_count;
      rei_have_q <= 1'b1;
    end else if (tx_frame) begin
      rei_have_q <= 1'b0;
    end
  end

  // Transmit code by priority; forced trace mismatch counts as connectivity
  always_comb begin
    if (!tx_enhanced_defect_sel) begin
      tx_code = (ais_cause || lop_cause) ? CODE_RDI_A : CODE_NONE_A;
    end else if (ais_cause || lop_cause) begin
      tx_code = CODE_SERVER;
    end else if (uneq_cause || force_tim) begin
      tx_code = CODE_CONNECT;
    end else if (plm_cause || lcd_cause) begin
      tx_code = CODE_PAYLOAD;
    end else begin
      tx_code = CODE_ENH_NONE;
    end
  end

  // Transmit overhead octets once per frame tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oh.dev_frame <= 1'b0;
      oh.dev_g1    <= OCTET_RESET;
      oh.dev_user  <= OCTET_RESET;
      oh.dev_mfi   <= OCTET_RESET;
      oh.dev_grow1 <= OCTET_RESET;
      oh.dev_grow2 <= OCTET_RESET;
    end else begin
      oh.dev_frame <= tx_frame;
      if (tx_frame) begin
        oh.dev_g1    <= {(rei_have_q ? rei_hold_q : 4'h0), tx_code, 1'b0};
        oh.dev_user  <= tx_octets_q[USER_LSB +: 8];
        oh.dev_mfi   <= tx_octets_q[MFI_LSB +: 8];
        oh.dev_grow1 <= tx_octets_q[GROW1_LSB +: 8];
        oh.dev_grow2 <= tx_octets_q[GROW2_LSB +: 8];
      end
    end
  end
endmodule : path_status_oh

// ==== verification/path_status_monitor.sv ====
// Checker for the overhead link between the two ends
`timescale 1ns/1ps
module path_status_monitor
  import path_status_pkg::*;
(
  input wire logic       clk,       // Clock
  input wire logic       rstn,      // Reset, active low
  input wire logic       dev_frame, // Device strobe
  input wire logic [7:0] dev_g1,    // Device status octet
  input wire logic [7:0] dev_user,  // User channel
  input wire logic [7:0] dev_mfi,   // Multiframe
  input wire logic [7:0] dev_grow1, // Growth one
  input wire logic [7:0] dev_grow2, // Growth two
  input wire logic       far_frame, // Far end strobe
  input wire logic [7:0] far_g1     // Far end status octet
);
  wire logic [31:0] octets = {dev_grow2, dev_grow1, dev_mfi, dev_user};
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Octets move only with a strobe, else a frame would be torn
  dev_hold_a: assert property ($changed(dev_g1) |-> dev_frame)
    else $error("device status moved between frames");
  octet_hold_a: assert property ($changed(octets) |-> dev_frame)
    else $error("device octets moved between frames");
  far_hold_a: assert property ($changed(far_g1) |-> far_frame)
    else $error("far status moved between frames");
  // Count at most eight; bits 6 and 7 never both set by these senders
  dev_count_a: assert property (dev_frame |-> dev_g1[7:4] <= REI_MAX)
    else $error("device count above eight");
  far_count_a: assert property (far_frame |-> far_g1[7:4] <= REI_MAX)
    else $error("far count above eight");
  dev_spare_a: assert property (dev_frame |-> !dev_g1[0])
    else $error("device spare bit set");
  dev_code_a: assert property (dev_frame |-> dev_g1[2:1] != 2'b11)
    else $error("device sent an unused code");
  far_code_a: assert property (far_frame |-> far_g1[2:1] != 2'b11)
    else $error("far end sent an unused code");
  cover property (dev_frame && dev_g1[3:1] == CODE_SERVER);
  cover property (dev_frame && dev_g1[7:4] == REI_MAX);
  cover property (far_frame && far_g1[3:1] == CODE_CONNECT);
endmodule : path_status_monitor

// ==== verification/wis_path_status_overhead_test.sv ====
// Bench for the device end joined to the far end framer
`timescale 1ns/1ps
module wis_path_status_overhead_test;
  import path_status_pkg::*;
  logic        clk = 1'b0;
  logic        rstn, psel, penable, pwrite, pready, pslverr, tx_frame, rei_valid, rerr;
  logic        ais, lop, plm, lcd, uneq, irq_a, irq_b, send, far_enh, srv, con, pay, rdi;
  logic [2:0]  code;
  logic [3:0]  rei, rx_rei;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, octets, rdat;
  logic [9:0]  tbl [13];
  int          miscompares, n_compared;
  path_oh_if path_oh_if_i ();
  path_status_oh path_status_oh_i (.clk(clk), .rstn(rstn), .oh(path_oh_if_i.device),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_frame(tx_frame),
    .rei_valid(rei_valid), .rei_count(rei), .ais_cause(ais), .lop_cause(lop),
    .plm_cause(plm), .lcd_cause(lcd), .uneq_cause(uneq), .irq_out_a(irq_a),
    .irq_out_b(irq_b));
  far_path_framer far_path_framer_i (.clk(clk), .rstn(rstn), .oh(path_oh_if_i.far_end),
    .send_frame(send), .enhanced_sel(far_enh), .rei_count(rei), .server_cause(srv),
    .connect_cause(con), .payload_cause(pay), .rx_frame_q(), .rx_rei_q(rx_rei),
    .rx_code_q(code), .rx_rdi_q(rdi), .rx_octets_q(octets));
  path_status_monitor path_status_monitor_i (.clk(clk), .rstn(rstn),
    .dev_frame(path_oh_if_i.dev_frame), .dev_g1(path_oh_if_i.dev_g1),
    .dev_user(path_oh_if_i.dev_user), .dev_mfi(path_oh_if_i.dev_mfi),
    .dev_grow1(path_oh_if_i.dev_grow1), .dev_grow2(path_oh_if_i.dev_grow2),
    .far_frame(path_oh_if_i.far_frame), .far_g1(path_oh_if_i.far_g1));
  // 100 ns clock
  always #50 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : chk
  // APB master; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask : apb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rdat);
  endtask : rd
  // Far end frames with a gap, so each strobe stays a single pulse
  task automatic far_tx(input int n);
    repeat (n) begin
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask : far_tx
  // Optional count word, then one device frame
  task automatic dev_tx(input logic v, input logic [3:0] c);
    {rei_valid, rei} <= {v, c};
    @(posedge clk);
    {rei_valid, tx_frame} <= 2'b01;
    @(posedge clk);
    tx_frame <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : dev_tx
  // Nine frames must not change the state; the tenth must
  task automatic persist(input logic [3:0] s9, pd, st, input logic ia, ib);
    far_tx(9);
    rd("status at nine", STATUS_OFS, {28'h0, s9});
    far_tx(1);
    chk("irq a", {31'h0, ia}, {31'h0, irq_a});
    chk("irq b", {31'h0, ib}, {31'h0, irq_b});
    rd("pending", PENDING_OFS, {28'h0, pd});
    rd("status", STATUS_OFS, {28'h0, st});
  endtask : persist
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // Hang guard; the run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    // {tx enhanced, force mismatch, ais lop plm lcd uneq, expected code}
    tbl = '{10'b1_0_00000_001, 10'b1_0_10000_101, 10'b1_0_01000_101, 10'b1_0_00100_010,
            10'b1_0_00010_010, 10'b1_0_00001_110, 10'b1_1_00000_110, 10'b1_1_11111_101,
            10'b1_0_00101_110, 10'b0_0_10000_100, 10'b0_0_01000_100, 10'b0_0_00111_000,
            10'b0_1_00000_000};
    {psel, penable, pwrite, tx_frame, rei_valid, ais, lop, plm, lcd, uneq} = '0;
    {send, far_enh, srv, con, pay, paddr, pwdata, rei} = '0;
    miscompares = 0;
    n_compared = 0;
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd("ctrl", CTRL_OFS, 32'(CTRL_RESET));
    rd("octets", TX_OCTETS_OFS, TX_OCTETS_RESET);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    chk("unmapped", 32'h0000_0001, {31'h0, rerr});
    rd("ctrl kept", CTRL_OFS, 32'(CTRL_RESET));
    $display("test reset finished");
    // Octets and error counts across the link
    dev_tx(1'b0, 4'h0);
    chk("octets default", 32'h0000_0000, octets);
    apb(1'b1, TX_OCTETS_OFS, 32'hA55A_3CC3);
    dev_tx(1'b1, 4'h5);
    chk("octets", 32'hA55A_3CC3, octets);
    chk("count", 32'h0000_0005, {28'h0, rx_rei});
    dev_tx(1'b0, 4'h3);
    chk("count empty", 32'h0000_0000, {28'h0, rx_rei});
    dev_tx(1'b1, 4'hC);
    chk("count clamp", 32'(REI_MAX), {28'h0, rx_rei});
    $display("test tx octets finished");
    // Transmitted code for a table of cause mixes in both modes
    foreach (tbl[i]) begin
      apb(1'b1, CTRL_OFS, {29'h0, tbl[i][8], tbl[i][9], 1'b1});
      {ais, lop, plm, lcd, uneq} <= tbl[i][7:3];
      repeat (2) @(posedge clk);
      dev_tx(1'b0, 4'h0);
      chk("code", {29'h0, tbl[i][2:0]}, {29'h0, code});
      chk("rdi", {31'h0, tbl[i][2]}, {31'h0, rdi});
    end
    $display("test tx codes finished");
    // Enhanced receive, masks route server to A and payload to B
    {ais, lop, plm, lcd, uneq} <= 5'h00;
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    apb(1'b1, MASK_A_OFS, 32'h0000_0005);
    apb(1'b1, MASK_B_OFS, 32'h0000_0002);
    {far_enh, srv} <= 2'b11;
    persist(4'h0, 4'h5, 4'h5, 1'b1, 1'b0);
    rd("pending cleared", PENDING_OFS, 32'h0000_0000);
    chk("irq a cleared", 32'h0000_0000, {31'h0, irq_a});
    srv <= 1'b0;
    persist(4'h1, 4'h0, 4'h0, 1'b0, 1'b0);
    pay <= 1'b1;
    persist(4'h0, 4'h3, 4'h3, 1'b1, 1'b1);
    {pay, con} <= 2'b01;
    persist(4'h1, 4'h8, 4'h9, 1'b1, 1'b0);
    con <= 1'b0;
    persist(4'h9, 4'h0, 4'h0, 1'b0, 1'b0);
    $display("test rx enhanced finished");
    // Single bit receive
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    {far_enh, srv} <= 2'b01;
    persist(4'h0, 4'h1, 4'h1, 1'b1, 1'b0);
    srv <= 1'b0;
    persist(4'h1, 4'h0, 4'h0, 1'b0, 1'b0);
    $display("test rx single finished");
    stop_test();
  end
endmodule : wis_path_status_overhead_test
